// ===== rtl/user_io_pkg.sv
// constants and types for the user indicator and touch polling block
// assumes one core clock at 250 MHz; the serial quarter and poll gap counts derive from it
package user_io_pkg;

    // clock rate
    localparam int CLK_PERIOD_NS = 4;

    // indicator layout
    localparam int LED_COUNT = 8;
    localparam int LED_KEY0 = 0;
    localparam int LED_KEY1 = 1;
    localparam int LED_SW0 = 2;
    localparam int LED_SW1 = 3;
    localparam int LED_BLINK0 = 4;
    localparam int LED_BLINK1 = 5;
    localparam int LED_PAD0 = 6;
    localparam int LED_PAD1 = 7;

    // blink divider: reference edges per 1 Hz period
    localparam int BLINK_DIV_RATIO = 50000000;

    // touch controller access
    localparam logic [7:0] TOUCH_ADDR = 8'h6e;
    localparam logic [7:0] READ_FLAG = 8'h01;
    localparam logic [7:0] TOUCH_STATUS_REG = 8'haa;
    localparam logic [7:0] IDLE_BYTE = 8'hff;
    localparam logic [1:0] UNTOUCHED = 2'h3;

    // transaction byte slots
    localparam logic [1:0] BYTE_ADDR_WR = 2'h0;
    localparam logic [1:0] BYTE_REG = 2'h1;
    localparam logic [1:0] BYTE_ADDR_RD = 2'h2;
    localparam logic [1:0] BYTE_DATA = 2'h3;
    localparam logic [3:0] ACK_BIT = 4'h8;
    localparam logic [2:0] MSB_BIT = 3'h7;

    // quarter bit phases
    localparam logic [1:0] Q0 = 2'h0;
    localparam logic [1:0] Q1 = 2'h1;
    localparam logic [1:0] Q2 = 2'h2;
    localparam logic [1:0] Q3 = 2'h3;

    // serial timing: quarter of a 100 kHz bit, least time rounds up
    localparam int I2C_QUARTER_NS = 2500;
    localparam int I2C_QUARTER_CYC =
        (I2C_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // pause between polls
    localparam int POLL_GAP_NS = 1000000;
    localparam int POLL_GAP_CYC = POLL_GAP_NS / CLK_PERIOD_NS;

    // breathing: pwm periods per duty step
    localparam int PWM_BITS = 8;
    localparam int BREATH_HOLD = 1000;

    typedef enum logic [2:0] {
        ST_GAP, ST_START, ST_BITS, ST_RSTART, ST_STOP
    } i2c_state_t;

endpackage

// ===== rtl/user_io_touch_led_demo.sv
// user buttons, switches, blink dividers, touch polling and breathing leds
// assumes ref clocks and pins sampled on core_clk; pins are open drain
`timescale 1ns/10ps
`default_nettype none

module user_io_touch_led_demo #(
    parameter int DIV_RATIO = user_io_pkg::BLINK_DIV_RATIO,
    parameter int QUARTER_CYC = user_io_pkg::I2C_QUARTER_CYC,
    parameter int POLL_GAP_CYC = user_io_pkg::POLL_GAP_CYC,
    parameter int BREATH_HOLD = user_io_pkg::BREATH_HOLD
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [1:0] push_button_n,
    input wire logic [1:0] slide_switch,
    input wire logic ref_clk_a,
    input wire logic ref_clk_b,
    input wire logic breathe_mode,
    input wire logic touch_scl_in,
    output logic touch_scl_out,
    output logic touch_scl_oe_n,
    input wire logic touch_sda_in,
    output logic touch_sda_out,
    output logic touch_sda_oe_n,
    output logic [7:0] indicator_outputs
);

    localparam logic [31:0] HALF_M1 = 32'(DIV_RATIO / 2 - 1);
    localparam logic [15:0] QUARTER_M1 = 16'(QUARTER_CYC - 1);
    localparam logic [31:0] GAP_M1 = 32'(POLL_GAP_CYC - 1);
    localparam logic [15:0] HOLD_M1 = 16'(BREATH_HOLD - 1);
    localparam logic [7:0] PWM_MAX = 8'hff;

    // refuse settings the counters cannot serve
    if (DIV_RATIO < 2 || DIV_RATIO % 2 != 0) begin : bad_div
        $error("divide ratio must be even and at least 2");
    end
    if (QUARTER_CYC < 1 || QUARTER_CYC > 65535) begin : bad_quarter
        $error("quarter bit count out of range");
    end
    if (POLL_GAP_CYC < 1) begin : bad_gap
        $error("poll gap must be at least one cycle");
    end
    if (BREATH_HOLD < 1 || BREATH_HOLD > 65535) begin : bad_hold
        $error("breath hold count out of range");
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    function automatic logic [7:0] byte_tx(input logic [1:0] idx);
        case (idx)
            user_io_pkg::BYTE_ADDR_WR: byte_tx = user_io_pkg::TOUCH_ADDR;
            user_io_pkg::BYTE_REG: byte_tx = user_io_pkg::TOUCH_STATUS_REG;
            user_io_pkg::BYTE_ADDR_RD:
                byte_tx = user_io_pkg::TOUCH_ADDR | user_io_pkg::READ_FLAG;
            default: byte_tx = user_io_pkg::IDLE_BYTE;
        endcase
    endfunction

    // ---------------- blink dividers ----------------
    logic [1:0] ref_prev;
    logic [31:0] div_cnt [2];
    logic [1:0] blink;
    wire [1:0] ref_now = {ref_clk_b, ref_clk_a};
    wire [1:0] ref_rise = ref_now & ~ref_prev;

    // count reference rising edges, toggle every half ratio
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ref_prev <= 2'h0;
            blink <= 2'h0;
            div_cnt[0] <= 32'h0;
            div_cnt[1] <= 32'h0;
        end else begin
            ref_prev <= ref_now;
            for (int i = 0; i < 2; i++) begin
                if (ref_rise[i]) begin
                    if (div_cnt[i] == HALF_M1) begin
                        div_cnt[i] <= 32'h0;
                        blink[i] <= ~blink[i];
                    end else begin
                        div_cnt[i] <= div_cnt[i] + 32'h1;
                    end
                end
            end
        end
    end

    // ---------------- touch polling master ----------------
    user_io_pkg::i2c_state_t state, next_state;
    logic [1:0] phase, next_phase;
    logic [3:0] bit_idx, next_bit;
    logic [1:0] byte_idx, next_byte;
    logic scl_low, next_scl;
    logic sda_low, next_sda;
    logic [7:0] rx_shift, next_rx;
    logic ack_ok, next_ack;
    logic [1:0] touch, next_touch;
    logic [31:0] gap_cnt, next_gap;
    logic [15:0] qcnt;

    // hold the quarter timer while a released clock is held low
    wire stall = !scl_low && !touch_scl_in;
    wire running = state != user_io_pkg::ST_GAP;
    wire tick = running && !stall && qcnt == QUARTER_M1;
    wire [7:0] tx_byte = byte_tx(byte_idx);
    wire tx_bit = tx_byte[user_io_pkg::MSB_BIT - bit_idx[2:0]];
    wire is_ack = bit_idx == user_io_pkg::ACK_BIT;
    wire is_rx = byte_idx == user_io_pkg::BYTE_DATA;
    wire drive_zero = !is_ack && !is_rx && !tx_bit;
    wire [1:0] touch_pad_0_1 = rx_shift[1:0];

    // sequence: start, addr w, reg, restart, addr r, data, nack, stop
    always_comb begin
        next_state = state;
        next_phase = phase;
        next_bit = bit_idx;
        next_byte = byte_idx;
        next_scl = scl_low;
        next_sda = sda_low;
        next_rx = rx_shift;
        next_ack = ack_ok;
        next_touch = touch;
        next_gap = gap_cnt;
        if (tick) begin
            next_phase = phase + 2'h1;
        end
        case (state)
            user_io_pkg::ST_GAP: begin
                next_scl = 1'b0;
                next_sda = 1'b0;
                next_phase = user_io_pkg::Q0;
                if (gap_cnt == GAP_M1) begin
                    next_gap = 32'h0;
                    next_state = user_io_pkg::ST_START;
                    next_ack = 1'b1;
                    next_byte = user_io_pkg::BYTE_ADDR_WR;
                    next_bit = 4'h0;
                end else begin
                    next_gap = gap_cnt + 32'h1;
                end
            end
            user_io_pkg::ST_START: begin
                if (tick) begin
                    case (phase)
                        user_io_pkg::Q0: next_sda = 1'b1;
                        user_io_pkg::Q2: next_scl = 1'b1;
                        user_io_pkg::Q3: next_state = user_io_pkg::ST_BITS;
                        default: next_sda = sda_low;
                    endcase
                end
            end
            user_io_pkg::ST_BITS: begin
                if (tick) begin
                    case (phase)
                        user_io_pkg::Q0: next_sda = drive_zero;
                        user_io_pkg::Q1: next_scl = 1'b0;
                        user_io_pkg::Q2: begin
                            if (is_ack && !is_rx) begin
                                next_ack = ack_ok && !touch_sda_in;
                            end else if (!is_ack && is_rx) begin
                                next_rx = {rx_shift[6:0], touch_sda_in};
                            end
                        end
                        default: begin
                            next_scl = 1'b1;
                            if (!is_ack) begin
                                next_bit = bit_idx + 4'h1;
                            end else begin
                                next_bit = 4'h0;
                                if (byte_idx == user_io_pkg::BYTE_REG) begin
                                    next_state = user_io_pkg::ST_RSTART;
                                end else if (is_rx) begin
                                    next_state = user_io_pkg::ST_STOP;
                                end else begin
                                    next_byte = byte_idx + 2'h1;
                                end
                            end
                        end
                    endcase
                end
            end
            user_io_pkg::ST_RSTART: begin
                if (tick) begin
                    case (phase)
                        user_io_pkg::Q0: next_sda = 1'b0;
                        user_io_pkg::Q1: next_scl = 1'b0;
                        user_io_pkg::Q2: next_sda = 1'b1;
                        default: begin
                            next_scl = 1'b1;
                            next_byte = user_io_pkg::BYTE_ADDR_RD;
                            next_state = user_io_pkg::ST_BITS;
                        end
                    endcase
                end
            end
            user_io_pkg::ST_STOP: begin
                if (tick) begin
                    case (phase)
                        user_io_pkg::Q0: next_sda = 1'b1;
                        user_io_pkg::Q1: next_scl = 1'b0;
                        user_io_pkg::Q2: next_sda = 1'b0;
                        default: begin
                            next_state = user_io_pkg::ST_GAP;
                            if (ack_ok) begin
                                next_touch = touch_pad_0_1;
                            end
                        end
                    endcase
                end
            end
            default: next_state = user_io_pkg::ST_GAP;
        endcase
    end

    // quarter bit timer
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            qcnt <= 16'h0;
        end else if (!running || tick) begin
            qcnt <= 16'h0;
        end else if (!stall) begin
            qcnt <= qcnt + 16'h1;
        end
    end

    // master state registers
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state <= user_io_pkg::ST_GAP;
            phase <= user_io_pkg::Q0;
            bit_idx <= 4'h0;
            byte_idx <= user_io_pkg::BYTE_ADDR_WR;
            scl_low <= 1'b0;
            sda_low <= 1'b0;
            rx_shift <= 8'h0;
            ack_ok <= 1'b0;
            touch <= user_io_pkg::UNTOUCHED;
            gap_cnt <= 32'h0;
        end else begin
            state <= next_state;
            phase <= next_phase;
            bit_idx <= next_bit;
            byte_idx <= next_byte;
            scl_low <= next_scl;
            sda_low <= next_sda;
            rx_shift <= next_rx;
            ack_ok <= next_ack;
            touch <= next_touch;
            gap_cnt <= next_gap;
        end
    end

    // open drain: only ever pull low
    assign touch_scl_out = 1'b0;
    assign touch_sda_out = 1'b0;
    assign touch_scl_oe_n = ~scl_low;
    assign touch_sda_oe_n = ~sda_low;

    // ---------------- breathing pwm ----------------
    logic [7:0] pwm_cnt;
    logic [7:0] duty;
    logic [15:0] hold_cnt;
    logic rising;
    wire [7:0] duty_b = PWM_MAX - duty;
    wire pwm_a = pwm_cnt < duty;
    wire pwm_b = pwm_cnt < duty_b;
    wire step = pwm_cnt == PWM_MAX && hold_cnt == HOLD_M1;

    // ramp duty up then down, one step per hold interval
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pwm_cnt <= 8'h0;
            hold_cnt <= 16'h0;
            duty <= 8'h0;
            rising <= 1'b1;
        end else begin
            pwm_cnt <= pwm_cnt + 8'h1;
            if (pwm_cnt == PWM_MAX) begin
                hold_cnt <= (hold_cnt == HOLD_M1) ? 16'h0 : hold_cnt + 16'h1;
            end
            if (step) begin
                if (rising && duty == PWM_MAX) begin
                    rising <= 1'b0;
                end else if (!rising && duty == 8'h0) begin
                    rising <= 1'b1;
                end else begin
                    duty <= rising ? duty + 8'h1 : duty - 8'h1;
                end
            end
        end
    end

    // ---------------- indicator drive ----------------
    wire [7:0] normal_leds = {touch[1], touch[0], blink[1], blink[0],
                              ~slide_switch[1], ~slide_switch[0],
                              push_button_n[1], push_button_n[0]};
    wire [7:0] breath_leds = {4{~pwm_b, ~pwm_a}};
    wire [7:0] next_leds = breathe_mode ? breath_leds : normal_leds;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            indicator_outputs <= 8'hff;
        end else begin
            indicator_outputs <= next_leds;
        end
    end

    // ---------------- checks ----------------
    AST_BUTTON_PASS: assert property (
        $past(nrst) && !$past(breathe_mode) |->
            indicator_outputs[user_io_pkg::LED_KEY0]
            == $past(push_button_n[0]))
        else $error("button indicator does not follow button");
    AST_SWITCH_INV: assert property (
        $past(nrst) && !$past(breathe_mode) |->
            indicator_outputs[user_io_pkg::LED_SW1]
            != $past(slide_switch[1]))
        else $error("switch indicator not inverted");
    AST_DIV_TOGGLE: assert property (
        $changed(blink[0]) |-> $past(ref_rise[0])
            && $past(div_cnt[0]) == HALF_M1)
        else $error("blink toggled at wrong count");
    AST_BLINK_LED: assert property (
        !breathe_mode ##1 !breathe_mode |=>
            indicator_outputs[user_io_pkg::LED_BLINK1] == $past(blink[1]))
        else $error("blink indicator not following divider");
    AST_ADDR_BYTE: assert property (
        state == user_io_pkg::ST_BITS && byte_idx == user_io_pkg::BYTE_ADDR_WR
            && tick && phase == user_io_pkg::Q0 && bit_idx == 4'h0
            |=> sda_low)
        else $error("address msb of 0x6e not driven low");
    AST_REG_BYTE: assert property (
        state == user_io_pkg::ST_BITS && byte_idx == user_io_pkg::BYTE_REG
            |-> tx_byte == user_io_pkg::TOUCH_STATUS_REG)
        else $error("status register address wrong");
    AST_TOUCH_UPDATE: assert property (
        $changed(touch) |-> $past(state) == user_io_pkg::ST_STOP
            && $past(ack_ok) && state == user_io_pkg::ST_GAP)
        else $error("touch status changed outside completed read");
    AST_PAD_LED: assert property (
        !breathe_mode ##1 !breathe_mode |=>
            indicator_outputs[user_io_pkg::LED_PAD0] == $past(touch[0]))
        else $error("pad indicator not following status");
    AST_PWM_DUTY: assert property (
        breathe_mode && pwm_a |=> !indicator_outputs[0])
        else $error("pwm high but indicator dark");
    AST_ANTIPHASE: assert property (
        breathe_mode && duty == PWM_MAX |=> indicator_outputs[1])
        else $error("second group lit while first at full");

endmodule // user_io_touch_led_demo

`default_nettype wire

// ===== verification/testbench.sv
// testbench for the user indicator and touch polling block
// assumes the touch controller model and pulled-up i2c lines
`timescale 1ns/10ps
`default_nettype none

module testbench;
    localparam int DIV = 4;
    localparam int REF_NS = 20;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic [1:0] push_button_n = 2'h3;
    logic [1:0] slide_switch = 2'h0;
    logic ref_clk_a = 1'b0;
    logic ref_clk_b = 1'b0;
    logic breathe_mode = 1'b0;
    logic [1:0] pad_touched = 2'h0;
    logic refuse_addr = 1'b0;
    logic stretch = 1'b0;
    wire logic scl_out, scl_oe_n, sda_out, sda_oe_n;
    wire logic sda_pull_n, scl_pull_n;
    wire logic [7:0] leds;
    wire scl_line = scl_oe_n & scl_pull_n;
    wire sda_line = sda_oe_n & sda_pull_n;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    int stops = 0;

    user_io_touch_led_demo #(.DIV_RATIO(DIV), .QUARTER_CYC(2),
        .POLL_GAP_CYC(20), .BREATH_HOLD(1)) dut_u (
        .core_clk(core_clk), .nrst(nrst), .push_button_n(push_button_n),
        .slide_switch(slide_switch), .ref_clk_a(ref_clk_a),
        .ref_clk_b(ref_clk_b), .breathe_mode(breathe_mode),
        .touch_scl_in(scl_line), .touch_scl_out(scl_out),
        .touch_scl_oe_n(scl_oe_n), .touch_sda_in(sda_line),
        .touch_sda_out(sda_out), .touch_sda_oe_n(sda_oe_n),
        .indicator_outputs(leds));

    touch_ctrl_model partner_u (.scl(scl_line), .sda(sda_line),
        .pad_touched(pad_touched), .refuse_addr(refuse_addr),
        .stretch(stretch), .sda_pull_n(sda_pull_n),
        .scl_pull_n(scl_pull_n));

    // core clock and two reference clocks off the core edges
    always #2 core_clk = ~core_clk;
    initial begin
        #1;
        forever #10 ref_clk_a = ~ref_clk_a;
    end
    initial begin
        #3;
        forever #10 ref_clk_b = ~ref_clk_b;
    end

    // stop conditions seen on the lines, and the hang limit
    always @(posedge sda_line) if (scl_line === 1'b1) stops++;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            final_report();
        end
    end

    task automatic check(input string what, input logic [15:0] exp,
            input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic test_reset();
        @(posedge core_clk);
        nrst <= 1'b0;
        tick(5);
        check("leds in reset", 16'h00ff, {8'h0, leds});
        check("oe in reset", 16'h0003, {14'h0, scl_oe_n, sda_oe_n});
        check("pin values", 16'h0000, {14'h0, scl_out, sda_out});
        @(posedge core_clk);
        nrst <= 1'b1;
        tick(2);
        check("touch after reset", 16'h0003, {14'h0, leds[7:6]});
        $display("test reset done");
    endtask

    task automatic test_direct();
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            push_button_n <= i[1:0];
            slide_switch <= i[1:0] ^ 2'h1;
            tick(1);
            check("buttons", {14'h0, i[1:0]}, {14'h0, leds[1:0]});
            check("switches", {14'h0, ~(i[1:0] ^ 2'h1)},
                {14'h0, leds[3:2]});
        end
        $display("test direct done");
    endtask

    task automatic wait_change(input int idx, output int n);
        logic prev;
        prev = leds[idx];
        n = 0;
        do begin
            tick(1);
            n++;
        end while (leds[idx] === prev && n < 200);
    endtask

    task automatic test_blink();
        int n;
        @(posedge core_clk);
        push_button_n <= 2'h0;
        for (int idx = 4; idx < 6; idx++) begin
            wait_change(idx, n);
            wait_change(idx, n);
            check("blink half period", DIV / 2 * REF_NS / 4, n);
        end
        $display("test blink done");
    endtask

    task automatic wait_stops(input int k);
        int n0;
        int n;
        n0 = stops;
        n = 0;
        while (stops < n0 + k && n < 3000) begin
            tick(1);
            n++;
        end
        tick(8);
    endtask

    task automatic test_touch(input logic [1:0] pads, input logic refuse,
            input logic str, input logic [1:0] exp);
        @(posedge core_clk);
        pad_touched <= pads;
        refuse_addr <= refuse;
        stretch <= str;
        wait_stops(2);
        check("touch leds", {14'h0, exp}, {14'h0, leds[7:6]});
        $display("test touch %h refuse %b done", pads, refuse);
    endtask

    task automatic lit_counts(output int a, output int b);
        a = 0;
        b = 0;
        repeat (256) begin
            tick(1);
            a += (leds[0] === 1'b0);
            b += (leds[1] === 1'b0);
            check("groups", {8'h0, leds}, {8'h0, {4{leds[1:0]}}});
        end
    endtask

    task automatic test_breathe();
        int a1, b1, a2, b2;
        @(posedge core_clk);
        breathe_mode <= 1'b1;
        tick(2);
        lit_counts(a1, b1);
        tick(2048);
        lit_counts(a2, b2);
        check("duty sum", 16'h1, {15'h0, a2 + b2 >= 254 && a2 + b2 <= 256});
        check("antiphase", 16'h1, {15'h0, (a2 - a1) * (b2 - b1) < 0});
        $display("test breathe done");
    endtask

    initial begin
        test_reset();
        test_direct();
        test_blink();
        for (int p = 0; p < 4; p++) begin
            test_touch(p[1:0], 1'b0, p == 2, ~p[1:0]);
        end
        test_touch(2'h0, 1'b1, 1'b0, 2'h0);
        test_touch(2'h0, 1'b0, 1'b0, 2'h3);
        pad_touched <= 2'h3;
        test_reset();
        test_breathe();
        final_report();
    end
endmodule // testbench

`default_nettype wire

// ===== verification/touch_ctrl_model.sv
// touch controller model: i2c target holding a two pad status register
// assumes pulled-up scl and sda lines resolved by the bench
`timescale 1ns/10ps
`default_nettype none

module touch_ctrl_model (
    input wire logic scl,
    input wire logic sda,
    input wire logic [1:0] pad_touched,
    input wire logic refuse_addr,
    input wire logic stretch,
    output logic sda_pull_n,
    output logic scl_pull_n
);
    logic [7:0] shreg;
    logic [7:0] tx;
    logic [7:0] want;
    int bit_n = 0;
    int n_byte = 0;
    logic active = 1'b0;
    logic reading = 1'b0;
    logic acked = 1'b0;

    initial begin
        sda_pull_n = 1'b1;
        scl_pull_n = 1'b1;
    end

    // start or repeated start, and stop
    always @(negedge sda) if (scl === 1'b1) begin
        active = 1'b1;
        reading = 1'b0;
        bit_n = 0;
    end
    always @(posedge sda) if (scl === 1'b1) begin
        active = 1'b0;
        n_byte = 0;
    end

    // shift in on rising scl
    always @(posedge scl) if (active) begin
        bit_n = bit_n + 1;
        if (bit_n <= 8) shreg = {shreg[6:0], sda};
    end

    // ack, stretch and read data, all changed while scl is low
    always @(negedge scl) if (active) begin
        sda_pull_n = 1'b1;
        if (!reading && bit_n == 8) begin
            want = (n_byte == 0) ? 8'h6e : (n_byte == 1) ? 8'haa : 8'h6f;
            acked = !refuse_addr && shreg == want;
            sda_pull_n = !acked;
            n_byte = n_byte + 1;
        end else if (!reading && bit_n == 9) begin
            bit_n = 0;
            if (acked && shreg == 8'h6f) begin
                reading = 1'b1;
                tx = {6'h15, ~pad_touched};
                sda_pull_n = tx[7];
            end
            if (stretch) begin
                scl_pull_n = 1'b0;
                #400;
                scl_pull_n = 1'b1;
            end
        end else if (reading && bit_n < 8) begin
            sda_pull_n = tx[7 - bit_n];
        end
    end
endmodule // touch_ctrl_model

`default_nettype wire
